/* File: shared/timer_counter_defs.svh */
// named constants for the timer/counter control block
`ifndef TIMER_COUNTER_DEFS_SVH
`define TIMER_COUNTER_DEFS_SVH

// ====================================================================
// register byte offsets
`define OFS_COMPARE_A_LOW 8'h10
`define OFS_COMPARE_A_HIGH 8'h11
`define OFS_CAPTURE_B_LOW 8'h12
`define OFS_CAPTURE_B_HIGH 8'h13
`define OFS_TIMER_CONTROL 8'h14

// ====================================================================
// reset values
`define RST_DATA_REG 16'hFFFF
`define RST_CONTROL 8'h00
`define RST_ZERO16 16'h0000
`define RST_ZERO8 8'h00

// ====================================================================
// control register field positions
`define CTL_MODE_LSB 0
`define CTL_CLK_LSB 2
`define CTL_START_LSB 4
`define CTL_CAPTURE_BIT 6
`define CTL_TFF_BIT 7

// ====================================================================
// prescaler taps: source clock is high clock over 2 to this power
`define DIV_EXP_SLOW 11
`define DIV_EXP_MID 7
`define DIV_EXP_FAST 3
`define PRESCALE_W 11
`define LOW_DIV_MAX 3'h7

`endif

/* File: shared/timer_counter_pkg.sv */
// types shared by the timer/counter control block
package timer_counter_pkg;

   // ====================================================================
   // operating mode field codes
   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00, // timer, external trigger or event counter
      MODE_WINDOW = 2'b01,
      MODE_PULSE_WIDTH = 2'b10,
      MODE_PULSE_OUT = 2'b11
   } operating_mode_e;

   // source clock field codes
   typedef enum logic [1:0] {
      CLK_DIV_SLOW = 2'b00,
      CLK_DIV_MID = 2'b01,
      CLK_DIV_FAST = 2'b10,
      CLK_EXT_PIN = 2'b11
   } source_clock_e;

   // start control field codes
   typedef enum logic [1:0] {
      START_STOP = 2'b00,
      START_COMMAND = 2'b01,
      START_RISING = 2'b10,
      START_FALLING = 2'b11
   } start_control_e;

   // counter sequencing states
   typedef enum logic [1:0] {
      RUN_HALTED = 2'b00,
      RUN_ARMED = 2'b01,
      RUN_COUNTING = 2'b10
   } run_state_e;

endpackage

/* File: logic/timer_counter.sv */
// 16-bit up-counting timer/counter with control and compare/capture registers
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "timer_counter_defs.svh"

module timer_counter
   import timer_counter_pkg::*;
(
   input wire logic core_clk_in, // 50 MHz core clock, stands for the high clock
   input wire logic rst_in, // synchronous, active high
   input wire logic [7:0] addr_in, // register byte address
   input wire logic [7:0] wdata_in, // write data
   input wire logic wr_in, // one-cycle write strobe
   input wire logic rd_in, // one-cycle read strobe
   output logic [7:0] rdata_out, // read data, cycle after the strobe
   input wire logic timer_input_pin_in, // external pin, asynchronous
   input wire logic low_freq_clock_in, // low clock, sampled as a level
   input wire logic divider_clock_option_in, // selects low clock for code 00
   input wire logic slow_mode_in, // chip in slow or sleep mode
   input wire logic stop_mode_in, // chip entering stop mode
   output logic timer_match_irq_out // one-cycle request pulse
);

   // ====================================================================
   // decode helpers

   // tick once every 2**exp cycles of the free prescaler
   function automatic logic div_tick(input logic [`PRESCALE_W-1:0] pre, input int exp);
      logic all_ones;
      all_ones = 1'b1;
      for (int i = 0; i < `PRESCALE_W; i++) begin
         if (i < exp) begin
            all_ones = all_ones & pre[i];
         end
      end
      return all_ones;
   endfunction

   // chosen pin edge: rising for start code 10, falling for 11
   function automatic logic pin_edge(input logic falling_sel, input logic cur, input logic prev);
      return falling_sel ? (prev & ~cur) : (cur & ~prev);
   endfunction

   // ====================================================================
   // input synchronisers
   logic [2:0] pin_sync; // [0] meta, [1] stable, [2] previous
   logic [2:0] low_sync; // same layout for the low clock
   logic [2:0] next_pin_sync;
   logic [2:0] next_low_sync;

   // shift pins through two stages plus one history stage
   always_comb begin
      next_pin_sync = {pin_sync[1:0], timer_input_pin_in};
      next_low_sync = {low_sync[1:0], low_freq_clock_in};
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pin_sync <= 3'h0;
         low_sync <= 3'h0;
      end else begin
         pin_sync <= next_pin_sync;
         low_sync <= next_low_sync;
      end
   end

   // ====================================================================
   // registers and counter state
   logic [1:0] operating_mode_select;
   logic [1:0] source_clock_select;
   logic [1:0] start_control_field;
   logic auto_capture_enable;
   logic output_flipflop_control; // stored only; pulse output is not built here
   logic [15:0] compare_register_a; // active compare value
   logic [15:0] compare_a_buffer; // shift-in buffer, loads on a tick
   logic compare_a_pending;
   logic [15:0] capture_register_b; // active B value
   logic [15:0] capture_b_buffer;
   logic capture_b_pending;
   logic [15:0] up_counter;
   run_state_e run_state;
   logic [`PRESCALE_W-1:0] prescaler; // free-running high clock divider
   logic [2:0] low_div; // low clock edge divider
   logic [7:0] rdata;
   logic match_irq;

   logic [1:0] next_operating_mode_select;
   logic [1:0] next_source_clock_select;
   logic [1:0] next_start_control_field;
   logic next_auto_capture_enable;
   logic next_output_flipflop_control;
   logic [15:0] next_compare_register_a;
   logic [15:0] next_compare_a_buffer;
   logic next_compare_a_pending;
   logic [15:0] next_capture_register_b;
   logic [15:0] next_capture_b_buffer;
   logic next_capture_b_pending;
   logic [15:0] next_up_counter;
   run_state_e next_run_state;
   logic [`PRESCALE_W-1:0] next_prescaler;
   logic [2:0] next_low_div;
   logic [7:0] next_rdata;
   logic next_match_irq;

   // derived strobes
   logic low_edge; // rising edge of the synchronised low clock
   logic src_tick; // one pulse of the selected source clock
   logic start_edge; // selected pin edge
   logic ext_counting; // source is the pin (event counter)
   logic needs_trigger; // counting waits for a pin edge
   logic count_enable; // window gating or plain running
   logic count_now;

   // ====================================================================
   // source clock selection and start conditions
   always_comb begin
      low_edge = low_sync[1] & ~low_sync[2];
      start_edge = pin_edge(start_control_field[0], pin_sync[1], pin_sync[2]);
      ext_counting = (source_clock_select == CLK_EXT_PIN);
      src_tick = 1'b0;
      // slow and sleep only allow code 00 from the low clock
      if (slow_mode_in) begin
         src_tick = (source_clock_select == CLK_DIV_SLOW) && low_edge
            && (low_div == `LOW_DIV_MAX);
      end else begin
         case (source_clock_select)
            CLK_DIV_SLOW: begin
               src_tick = divider_clock_option_in
                  ? (low_edge && (low_div == `LOW_DIV_MAX))
                  : div_tick(prescaler, `DIV_EXP_SLOW);
            end
            CLK_DIV_MID: src_tick = div_tick(prescaler, `DIV_EXP_MID);
            CLK_DIV_FAST: src_tick = div_tick(prescaler, `DIV_EXP_FAST);
            CLK_EXT_PIN: begin
               // event counting: the start code chooses the counted edge
               src_tick = (start_control_field == START_COMMAND)
                  ? (pin_sync[1] & ~pin_sync[2])
                  : start_edge;
            end
            default: src_tick = 1'b0;
         endcase
      end
      // start codes 10 and 11 wait for a pin edge in every mode except window, unless the pin is the source
      needs_trigger = start_control_field[1] && !ext_counting
         && (operating_mode_select != MODE_WINDOW);
      // window mode gates the source clock by the pin level and polarity
      if (operating_mode_select == MODE_WINDOW) begin
         count_enable = start_control_field[0] ? ~pin_sync[1] : pin_sync[1];
      end else begin
         count_enable = 1'b1;
      end
      // a cleared start field stops counting at once, before the sequencer catches up
      count_now = src_tick && count_enable && (run_state == RUN_COUNTING)
         && (start_control_field != START_STOP);
   end

   // ====================================================================
   // register file, counter and sequencer next state
   always_comb begin
      next_operating_mode_select = operating_mode_select;
      next_source_clock_select = source_clock_select;
      next_start_control_field = start_control_field;
      next_auto_capture_enable = auto_capture_enable;
      next_output_flipflop_control = output_flipflop_control;
      next_compare_register_a = compare_register_a;
      next_compare_a_buffer = compare_a_buffer;
      next_compare_a_pending = compare_a_pending;
      next_capture_register_b = capture_register_b;
      next_capture_b_buffer = capture_b_buffer;
      next_capture_b_pending = capture_b_pending;
      next_up_counter = up_counter;
      next_run_state = run_state;
      next_prescaler = prescaler + `PRESCALE_W'(1);
      next_low_div = low_edge ? low_div + 3'h1 : low_div;
      next_rdata = `RST_ZERO8;
      next_match_irq = 1'b0;

      // buffered values take effect on a source tick
      if (src_tick && compare_a_pending) begin
         next_compare_register_a = compare_a_buffer;
         next_compare_a_pending = 1'b0;
      end
      if (src_tick && capture_b_pending) begin
         next_capture_register_b = capture_b_buffer;
         next_capture_b_pending = 1'b0;
      end

      // software writes; a tick in the same cycle loses to the new upper byte
      if (wr_in) begin
         case (addr_in)
            `OFS_COMPARE_A_LOW: next_compare_a_buffer[7:0] = wdata_in;
            `OFS_COMPARE_A_HIGH: begin
               next_compare_a_buffer[15:8] = wdata_in;
               next_compare_a_pending = 1'b1;
            end
            `OFS_CAPTURE_B_LOW: begin
               if (operating_mode_select == MODE_PULSE_OUT) begin
                  next_capture_b_buffer[7:0] = wdata_in;
               end
            end
            `OFS_CAPTURE_B_HIGH: begin
               // B is writable only in pulse-output mode
               if (operating_mode_select == MODE_PULSE_OUT) begin
                  next_capture_b_buffer[15:8] = wdata_in;
                  next_capture_b_pending = 1'b1;
               end
            end
            `OFS_TIMER_CONTROL: begin
               next_operating_mode_select = wdata_in[`CTL_MODE_LSB +: 2];
               next_source_clock_select = wdata_in[`CTL_CLK_LSB +: 2];
               next_start_control_field = wdata_in[`CTL_START_LSB +: 2];
               next_auto_capture_enable = wdata_in[`CTL_CAPTURE_BIT];
               next_output_flipflop_control = wdata_in[`CTL_TFF_BIT];
            end
            default: begin
               // unmapped addresses are ignored
            end
         endcase
      end

      // stop mode entry overrides a simultaneous software start
      if (stop_mode_in) begin
         next_start_control_field = START_STOP;
      end

      // sequencer
      case (run_state)
         RUN_HALTED: begin
            next_up_counter = `RST_ZERO16;
            if (start_control_field != START_STOP) begin
               next_run_state = needs_trigger ? RUN_ARMED : RUN_COUNTING;
            end
         end
         RUN_ARMED: begin
            // waiting for the selected pin edge
            if (start_edge) begin
               next_run_state = RUN_COUNTING;
            end
         end
         RUN_COUNTING: begin
            if (count_now) begin
               if (up_counter == compare_register_a) begin
                  next_match_irq = 1'b1;
                  next_up_counter = `RST_ZERO16;
                  // trigger-started timing halts and rearms after a match
                  if (needs_trigger && operating_mode_select == MODE_TIMER) begin
                     next_run_state = RUN_ARMED;
                  end
               end else begin
                  next_up_counter = up_counter + 16'h0001;
               end
            end
         end
         default: next_run_state = RUN_HALTED;
      endcase

      // stopped field holds the counter cleared regardless of state
      if (start_control_field == START_STOP) begin
         next_up_counter = `RST_ZERO16;
         next_run_state = RUN_HALTED;
      end

      // auto-capture samples on every source tick; stale once stopped
      if (auto_capture_enable && src_tick && start_control_field != START_STOP) begin
         next_capture_register_b = up_counter;
      end

      // read data for the following cycle
      if (rd_in) begin
         case (addr_in)
            `OFS_COMPARE_A_LOW: next_rdata = compare_register_a[7:0];
            `OFS_COMPARE_A_HIGH: next_rdata = compare_register_a[15:8];
            `OFS_CAPTURE_B_LOW: next_rdata = capture_register_b[7:0];
            `OFS_CAPTURE_B_HIGH: next_rdata = capture_register_b[15:8];
            `OFS_TIMER_CONTROL: begin
               next_rdata = {output_flipflop_control, auto_capture_enable,
                  start_control_field, source_clock_select, operating_mode_select};
            end
            default: next_rdata = `RST_ZERO8;
         endcase
      end
   end

   // register everything
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         operating_mode_select <= MODE_TIMER;
         source_clock_select <= CLK_DIV_SLOW;
         start_control_field <= START_STOP;
         auto_capture_enable <= 1'b0;
         output_flipflop_control <= 1'b0;
         compare_register_a <= `RST_DATA_REG;
         compare_a_buffer <= `RST_DATA_REG;
         compare_a_pending <= 1'b0;
         capture_register_b <= `RST_DATA_REG;
         capture_b_buffer <= `RST_DATA_REG;
         capture_b_pending <= 1'b0;
         up_counter <= `RST_ZERO16;
         run_state <= RUN_HALTED;
         prescaler <= `PRESCALE_W'(0);
         low_div <= 3'h0;
         rdata <= `RST_ZERO8;
         match_irq <= 1'b0;
      end else begin
         operating_mode_select <= next_operating_mode_select;
         source_clock_select <= next_source_clock_select;
         start_control_field <= next_start_control_field;
         auto_capture_enable <= next_auto_capture_enable;
         output_flipflop_control <= next_output_flipflop_control;
         compare_register_a <= next_compare_register_a;
         compare_a_buffer <= next_compare_a_buffer;
         compare_a_pending <= next_compare_a_pending;
         capture_register_b <= next_capture_register_b;
         capture_b_buffer <= next_capture_b_buffer;
         capture_b_pending <= next_capture_b_pending;
         up_counter <= next_up_counter;
         run_state <= next_run_state;
         prescaler <= next_prescaler;
         low_div <= next_low_div;
         rdata <= next_rdata;
         match_irq <= next_match_irq;
      end
   end

   // ====================================================================
   // outputs straight from flip-flops
   assign rdata_out = rdata;
   assign timer_match_irq_out = match_irq;

endmodule

/* File: verification/timer_counter_sva.sv */
// port-level checker for the timer/counter block
`timescale 1ns/10ps
`include "timer_counter_defs.svh"
module timer_counter_checker
   import timer_counter_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic timer_input_pin_in,
   input wire logic low_freq_clock_in,
   input wire logic divider_clock_option_in,
   input wire logic slow_mode_in,
   input wire logic stop_mode_in,
   input wire logic timer_match_irq_out
);
   // ======================================================================
   // shadow of the control register as software should see it
   logic [7:0] ctl_shadow; // mirror of control contents
   logic [7:0] next_ctl_shadow; // mirror next value
   logic ctl_hit; // access aims at control
   assign ctl_hit = (addr_in == `OFS_TIMER_CONTROL);
   // other fields of a same-cycle write still land; only the start field is cleared
   always_comb begin
      next_ctl_shadow = ctl_shadow;
      if (wr_in && ctl_hit) begin
         next_ctl_shadow = wdata_in;
      end
      // stop entry beats the start field of a same-cycle write
      if (stop_mode_in) begin
         next_ctl_shadow[5:4] = 2'h0;
      end
   end
   // register the mirror
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ctl_shadow <= `RST_CONTROL;
      end else begin
         ctl_shadow <= next_ctl_shadow;
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // ======================================================================
   // properties
   property p_rdata_idle;
      !$past(rd_in) |-> rdata_out == 8'h00;
   endproperty
   property p_ctl_readback;
      rd_in && ctl_hit |=> rdata_out == $past(ctl_shadow);
   endproperty
   property p_unmapped_read;
      rd_in && (addr_in < `OFS_COMPARE_A_LOW || addr_in > `OFS_TIMER_CONTROL) |=> rdata_out == 8'h00;
   endproperty
   property p_irq_single;
      timer_match_irq_out |=> !timer_match_irq_out;
   endproperty
   property p_irq_spacing;
      $rose(timer_match_irq_out) |=> (!timer_match_irq_out) [*8];
   endproperty
   property p_stop_quiet;
      stop_mode_in ##1 stop_mode_in |=> !timer_match_irq_out;
   endproperty
   property p_halt_quiet;
      (ctl_shadow[5:4] == 2'h0) [*2] |-> !timer_match_irq_out;
   endproperty
   property p_slow_no_fast;
      (slow_mode_in && ctl_shadow[3:2] != 2'h0) [*2] |-> !timer_match_irq_out;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_ctl_readback: assert property (p_ctl_readback) else $error("control readback");
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");
   a_irq_single: assert property (p_irq_single) else $error("request too long");
   a_irq_spacing: assert property (p_irq_spacing) else $error("requests too close");
   a_stop_quiet: assert property (p_stop_quiet) else $error("request in stop");
   a_halt_quiet: assert property (p_halt_quiet) else $error("request while halted");
   a_slow_no_fast: assert property (p_slow_no_fast) else $error("fast tick in slow");
   c_irq: cover property (timer_match_irq_out);
   c_stop_read: cover property (stop_mode_in && rd_in && ctl_hit);
   c_slow_irq: cover property (slow_mode_in && timer_match_irq_out);
endmodule

bind timer_counter timer_counter_checker chk_u (.*);

/* File: verification/tb_timer_counter_control_and_timer_mode.sv */
// self-checking bench for the timer/counter block
`timescale 1ns/10ps
`include "timer_counter_defs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: value mismatch", $time); end end
module tb_timer_counter_control_and_timer_mode;
   import timer_counter_pkg::*;
   // ======================================================================
   // signals
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic pin = 1'b0; // external timer pin
   logic low_clk = 1'b0; // low clock, eight core cycles a period
   logic [2:0] low_cnt = 3'h0; // divides core clock for low clock
   logic div_opt = 1'b0;
   logic slow = 1'b0;
   logic stop = 1'b0;
   logic irq;
   int n_mismatch = 0;
   int num_checks = 0;
   int n; // cycles waited
   bit hit; // request seen
   logic [7:0] rv; // read value
   // reset-value rows: address beside expected read data
   logic [7:0] row_addr [6] = '{8'h14, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
   logic [7:0] row_exp [6] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   timer_counter dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .timer_input_pin_in(pin), .low_freq_clock_in(low_clk),
      .divider_clock_option_in(div_opt), .slow_mode_in(slow), .stop_mode_in(stop),
      .timer_match_irq_out(irq));
   // ======================================================================
   // clock and low clock
   initial begin
      forever #10 core_clk_in = ~core_clk_in;
   end
   // low clock made on the core edge so its phase is known
   always @(posedge core_clk_in) begin
      low_cnt <= low_cnt + 3'h1;
      low_clk <= low_cnt[2];
   end
   // ======================================================================
   // bus and wait tasks
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   // data is taken mid-cycle, in the one cycle where it stands
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      @(negedge core_clk_in);
      d = rdata_out;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge core_clk_in);
   endtask
   // counts edges until one samples the request high, bounded
   task automatic wait_irq(input int lim, output int cnt, output bit seen);
      cnt = 0;
      seen = 1'b0;
      while (!seen && cnt < lim) begin
         @(posedge core_clk_in);
         cnt++;
         seen = (irq === 1'b1);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the expected few thousand cycles
   initial begin
      #400000;
      n_mismatch++;
      stop_test();
   end
   // ======================================================================
   // main sequence
   initial begin
      idle(6);
      rst_in <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_reg(row_addr[i], rv);
         `CHK(rv, row_exp[i])
      end
      // lower byte alone, and refused writes to B outside pulse-output
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      wr_reg(`OFS_COMPARE_A_LOW, 8'h02);
      wr_reg(`OFS_CAPTURE_B_LOW, 8'h55);
      wr_reg(`OFS_CAPTURE_B_HIGH, 8'h55);
      idle(20);
      rd_reg(`OFS_COMPARE_A_LOW, rv);
      `CHK(rv, 8'hFF)
      rd_reg(`OFS_CAPTURE_B_LOW, rv);
      `CHK(rv, 8'hFF)
      wr_reg(`OFS_COMPARE_A_HIGH, 8'h00);
      idle(20);
      rd_reg(`OFS_COMPARE_A_LOW, rv);
      `CHK(rv, 8'h02)
      rd_reg(`OFS_COMPARE_A_HIGH, rv);
      `CHK(rv, 8'h00)
      // timer mode, fast clock: match every three ticks of eight cycles
      wr_reg(`OFS_TIMER_CONTROL, 8'h18);
      wait_irq(200, n, hit);
      `CHK(hit, 1'b1)
      wait_irq(200, n, hit);
      `CHK(n, 24)
      // capture follows the counter, which never passes the compare value
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      wr_reg(`OFS_TIMER_CONTROL, 8'h58);
      wait_irq(200, n, hit);
      rd_reg(`OFS_CAPTURE_B_LOW, rv);
      `CHK(rv <= 8'h02, 1'b1)
      rd_reg(`OFS_CAPTURE_B_HIGH, rv);
      `CHK(rv, 8'h00)
      // stop mode clears the start field and silences the counter
      @(posedge core_clk_in);
      stop <= 1'b1;
      idle(3);
      rd_reg(`OFS_TIMER_CONTROL, rv);
      `CHK(rv, 8'h48)
      @(posedge core_clk_in);
      stop <= 1'b0;
      wait_irq(100, n, hit);
      `CHK(hit, 1'b0)
      // window mode, positive logic: counts only while the pin is high
      wr_reg(`OFS_TIMER_CONTROL, 8'h09);
      wr_reg(`OFS_TIMER_CONTROL, 8'h29);
      wait_irq(100, n, hit);
      `CHK(hit, 1'b0)
      pin <= 1'b1;
      wait_irq(100, n, hit);
      `CHK(hit, 1'b1)
      // slow mode refuses fast clock, then counts low clock over eight
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      slow <= 1'b1;
      wr_reg(`OFS_TIMER_CONTROL, 8'h18);
      wait_irq(100, n, hit);
      `CHK(hit, 1'b0)
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      wr_reg(`OFS_TIMER_CONTROL, 8'h10);
      wait_irq(400, n, hit);
      wait_irq(400, n, hit);
      `CHK(n, 192)
      // normal mode with divider option also picks low clock over eight
      slow <= 1'b0;
      div_opt <= 1'b1;
      wait_irq(400, n, hit);
      wait_irq(400, n, hit);
      `CHK(n, 192)
      // mid clock: match every three ticks of 128 cycles
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      wr_reg(`OFS_TIMER_CONTROL, 8'h14);
      wait_irq(500, n, hit);
      wait_irq(500, n, hit);
      `CHK(n, 384)
      // event counter: only the third rising pin edge reaches the compare value
      wr_reg(`OFS_TIMER_CONTROL, 8'h0C);
      wr_reg(`OFS_TIMER_CONTROL, 8'h1C);
      for (int k = 0; k < 3; k++) begin
         pin <= 1'b0;
         wait_irq(8, n, hit);
         `CHK(hit, 1'b0)
         pin <= 1'b1;
         wait_irq(8, n, hit);
         `CHK(hit, k == 2)
      end
      // trigger start: armed until a rising edge, armed again after the match
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      pin <= 1'b0;
      wr_reg(`OFS_TIMER_CONTROL, 8'h28);
      wait_irq(100, n, hit);
      `CHK(hit, 1'b0)
      pin <= 1'b1;
      wait_irq(100, n, hit);
      `CHK(hit, 1'b1)
      wait_irq(100, n, hit);
      `CHK(hit, 1'b0)
      // pulse-output mode accepts B once the mode is set, A kept above B
      wr_reg(`OFS_TIMER_CONTROL, 8'h08);
      wr_reg(`OFS_TIMER_CONTROL, 8'h0B);
      wr_reg(`OFS_COMPARE_A_LOW, 8'h00);
      wr_reg(`OFS_COMPARE_A_HIGH, 8'h30);
      wr_reg(`OFS_CAPTURE_B_LOW, 8'h34);
      wr_reg(`OFS_CAPTURE_B_HIGH, 8'h12);
      idle(20);
      rd_reg(`OFS_CAPTURE_B_LOW, rv);
      `CHK(rv, 8'h34)
      rd_reg(`OFS_CAPTURE_B_HIGH, rv);
      `CHK(rv, 8'h12)
      stop_test();
   end
endmodule
